// [spi_port_pkg.sv]
package spi_port_pkg;
    // select-mode field encodings
    localparam logic [1:0] SEL_3WIRE = 2'h0;
    localparam logic [1:0] SEL_4WIRE_IN = 2'h1;
    localparam int SEL_HIGH_POS = 1;
    localparam int SEL_LOW_POS = 0;
    // byte geometry
    localparam int BYTE_BITS = 8;
    localparam int MSB_POS = 7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // master serial clock: half period in system clocks
    localparam int SCK_HALF_NS = 200;
    localparam int CLK_NS = 50;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SCK_HALF_M1 = 4'(SCK_HALF_CYC - 1);
    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// [sync2.sv]
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for one level from outside the clock domain
module sync2 #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // first stage is read only by the second stage; reset to the pin's
    // idle level so no false edge follows reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [spi_port.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - master drives mosi, slave listens to it
// - master samples miso, slave drives it
// - bytes shift most significant bit first
// - master mosi shows shift register top bit
// - miso released when disabled or unselected
// - 3-wire slave always drives miso top bit
// - only master drives serial clock
// - 4-wire slave ignores sck while select high
// - mode 00: 3-wire, slave always selected
// - mode 01 slave: select pin addresses slave
// - mode 01 master: select fall disables master
// - mode 1x: select output follows low bit
// - select pin unrouted in 3-wire mode
// - every transfer is full duplex
// - mode fault clears enables, sets fault flag
// - 4-wire slave select fall resets bit counter
// - slave after eight bits: done, capture byte
// - master sets done flag at byte end
module spi_port (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [1:0] select_mode_field,
    input wire logic enable_set,
    input wire logic enable_clr,
    input wire logic master_set,
    input wire logic master_clr,
    input wire logic [7:0] tx_byte,
    input wire logic tx_write,
    input wire logic done_clr,
    input wire logic fault_clr,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic sck_in,
    input wire logic sel_in,
    output logic mosi_out,
    output logic mosi_oe,
    output logic miso_out,
    output logic miso_oe,
    output logic sck_out,
    output logic sck_oe,
    output logic sel_out,
    output logic sel_oe,
    output logic sel_routed,
    output logic port_enable_bit,
    output logic master_enable_bit,
    output logic mode_fault_flag,
    output logic transfer_done_flag,
    output logic [7:0] rx_byte,
    output logic busy
);
    typedef enum logic [1:0] {IDLE = 2'b00, LOW = 2'b01, HIGH = 2'b11} mst_e;
    mst_e mst_q;
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic [3:0] div_q;
    logic sck_s, sck_prev_q, sel_s, sel_prev_q, mosi_s, miso_s;
    logic mode3, sel_pin_out, selected, sck_rise, sck_fall, sel_fall;
    logic slave_act, master_done, slave_done, fault;
    logic samp_q;

    sync2 #(.RESET_VALUE(1'b0)) u_sck (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .async_in(sck_in), .sync_out(sck_s));
    sync2 #(.RESET_VALUE(1'b1)) u_sel (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .async_in(sel_in), .sync_out(sel_s));
    sync2 #(.RESET_VALUE(1'b0)) u_mosi (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .async_in(mosi_in), .sync_out(mosi_s));
    sync2 #(.RESET_VALUE(1'b0)) u_miso (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .async_in(miso_in), .sync_out(miso_s));

    // decode of the select mode and link edges
    assign mode3 = (select_mode_field == spi_port_pkg::SEL_3WIRE);
    assign sel_pin_out = select_mode_field[spi_port_pkg::SEL_HIGH_POS];
    // select synchroniser resets high, the idle level of the pin
    assign selected = mode3 || !sel_s;
    assign sck_rise = sck_s && !sck_prev_q;
    assign sck_fall = !sck_s && sck_prev_q;
    assign sel_fall = !sel_s && sel_prev_q;
    assign slave_act = port_enable_bit && !master_enable_bit;
    assign fault = master_enable_bit && port_enable_bit && sel_fall
        && select_mode_field == spi_port_pkg::SEL_4WIRE_IN;
    assign master_done = (mst_q == HIGH) && div_q == 4'h0
        && cnt_q == spi_port_pkg::LAST_BIT;
    assign slave_done = slave_act && selected && sck_rise
        && cnt_q == spi_port_pkg::LAST_BIT;

    // edge history for the synchronised link lines
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end else if (clk_en) begin
            sck_prev_q <= sck_s;
            sel_prev_q <= sel_s;
        end
    end

    // enable bits; a mode fault beats a software set
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            port_enable_bit <= 1'b0;
            master_enable_bit <= 1'b0;
        end else if (clk_en) begin
            if (fault) begin
                port_enable_bit <= 1'b0;
                master_enable_bit <= 1'b0;
            end else begin
                if (enable_set) port_enable_bit <= 1'b1;
                else if (enable_clr) port_enable_bit <= 1'b0;
                if (master_set) master_enable_bit <= 1'b1;
                else if (master_clr) master_enable_bit <= 1'b0;
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_fault_flag <= 1'b0;
            transfer_done_flag <= 1'b0;
        end else if (clk_en) begin
            if (fault) mode_fault_flag <= 1'b1;
            else if (fault_clr) mode_fault_flag <= 1'b0;
            if (master_done || slave_done) transfer_done_flag <= 1'b1;
            else if (done_clr) transfer_done_flag <= 1'b0;
        end
    end

    // master clock generator, mode 0 timing: sample rise, shift fall
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mst_q <= IDLE;
            div_q <= 4'h0;
        end else if (clk_en) begin
            unique case (mst_q)
                IDLE: if (master_enable_bit && port_enable_bit && tx_write) begin
                    mst_q <= LOW;
                    div_q <= spi_port_pkg::SCK_HALF_M1;
                end
                LOW: if (!master_enable_bit) mst_q <= IDLE;
                    else if (div_q != 4'h0) div_q <= div_q - 4'h1;
                    else begin
                        mst_q <= HIGH;
                        div_q <= spi_port_pkg::SCK_HALF_M1;
                    end
                HIGH: if (!master_enable_bit) mst_q <= IDLE;
                    else if (div_q != 4'h0) div_q <= div_q - 4'h1;
                    else begin
                        mst_q <= master_done ? IDLE : LOW;
                        div_q <= spi_port_pkg::SCK_HALF_M1;
                    end
                default: mst_q <= IDLE;
            endcase
        end
    end

    // shift register and bit counter, both roles, msb first
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= spi_port_pkg::BYTE_RESET;
            cnt_q <= 3'h0;
            rx_byte <= spi_port_pkg::BYTE_RESET;
            samp_q <= 1'b0;
        end else if (clk_en) begin
            if (!port_enable_bit) begin
                cnt_q <= 3'h0; // re-enable is the only 3-wire counter reset
            end else if (master_enable_bit) begin
                if (mst_q == IDLE && tx_write) begin
                    shift_q <= tx_byte;
                    cnt_q <= 3'h0;
                end else if (mst_q == LOW && div_q == 4'h0) begin
                    // sample at the rise; mosi must not move until the fall
                    samp_q <= miso_s;
                end else if (mst_q == HIGH && div_q == 4'h0) begin
                    shift_q <= {shift_q[6:0], samp_q};
                    cnt_q <= cnt_q + 3'h1;
                    if (master_done) rx_byte <= {shift_q[6:0], samp_q};
                end
            end else begin
                if (!mode3 && sel_fall) cnt_q <= 3'h0;
                else if (selected && sck_rise) begin
                    shift_q <= {shift_q[6:0], mosi_s};
                    cnt_q <= cnt_q + 3'h1;
                    if (slave_done) rx_byte <= {shift_q[6:0], mosi_s};
                end else if (tx_write && cnt_q == 3'h0 && !sck_s) begin
                    shift_q <= tx_byte;
                end
            end
        end
    end

    // registered pin drivers and directions
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            sel_out <= 1'b1;
            sel_oe <= 1'b0;
            sel_routed <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            mosi_out <= shift_q[spi_port_pkg::MSB_POS];
            mosi_oe <= port_enable_bit && master_enable_bit;
            miso_out <= shift_q[spi_port_pkg::MSB_POS];
            miso_oe <= slave_act && selected;
            sck_out <= (mst_q == HIGH);
            sck_oe <= port_enable_bit && master_enable_bit;
            sel_out <= select_mode_field[spi_port_pkg::SEL_LOW_POS];
            sel_oe <= sel_pin_out;
            sel_routed <= !mode3;
            busy <= (mst_q != IDLE) || (slave_act && cnt_q != 3'h0);
        end
    end

    // checks
    mode_fault_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && fault |=> !master_enable_bit
        && !port_enable_bit && mode_fault_flag)
        else $error("mode fault did not disable");
    miso_float_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && !port_enable_bit |=> !miso_oe)
        else $error("miso driven while disabled");
    miso_unsel_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && slave_act && !mode3 && sel_s
        |=> !miso_oe) else $error("miso driven while unselected");
    miso_3w_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && slave_act && mode3 |=> miso_oe
        && miso_out == $past(shift_q[7])) else $error("3w miso");
    mosi_dir_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en
        |=> mosi_oe == $past(port_enable_bit && master_enable_bit))
        else $error("mosi direction wrong");
    sck_slave_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && !master_enable_bit |=> !sck_oe)
        else $error("slave drove sck");
    sel_level_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && select_mode_field[1] |=> sel_oe
        && sel_out == $past(select_mode_field[0])) else $error("sel out");
    sel_route_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && mode3 |=> !sel_routed)
        else $error("sel routed");
    unsel_hold_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && slave_act && !mode3 && sel_s
        |=> $stable(cnt_q)) else $error("sck not ignored");
    slave_byte_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && slave_done
        |=> transfer_done_flag && cnt_q == 3'h0)
        else $error("slave byte end");
    master_byte_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && master_done
        |=> transfer_done_flag && mst_q == IDLE)
        else $error("master byte end");
    cnt_reset_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && slave_act && !mode3 && sel_fall
        |=> cnt_q == 3'h0) else $error("select fall no reset");
    master_xfer_c: cover property (@(posedge clk_sys) master_done);
    slave_xfer_c: cover property (@(posedge clk_sys) slave_done);
    fault_c: cover property (@(posedge clk_sys) fault);
endmodule
`default_nettype wire

// [spi_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
// far-end device: a master whose clock stops between frames, or a slave
module spi_far_end (
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    output logic sck_p,
    output logic mosi_p,
    output logic miso_p,
    output logic sel_p
);
    logic [7:0] sh_q = 8'h00;
    logic [7:0] got_q = 8'h00;
    logic is_m = 1'b0;
    // one shift register serves both roles, top bit on the line
    assign mosi_p = sh_q[7];
    assign miso_p = sh_q[7];
    initial begin
        sck_p = 1'b0;
        sel_p = 1'b1;
    end
    // capture on rise, shift on fall; refill toggles so stale bits differ
    always @(posedge sck_w) begin
        got_q = {got_q[6:0], is_m ? miso_w : mosi_w};
    end
    always @(negedge sck_w) begin
        sh_q = {sh_q[6:0], ~sh_q[0]};
    end
    // one frame of nbits with the given half period in ns
    task automatic xfer(input logic [7:0] tx, input int nbits, input int half);
        sh_q = tx;
        is_m = 1'b1;
        // keep link edges clear of the system clock edges
        #7;
        repeat (nbits) begin
            #(half) sck_p = 1'b1;
            #(half) sck_p = 1'b0;
        end
        is_m = 1'b0;
    endtask
endmodule
`default_nettype wire

// [test_spi_port.sv]
`timescale 1ns/10ps
`default_nettype none
module test_spi_port;
    logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
    logic [1:0] select_mode_field = 2'h0;
    logic enable_set = 1'b0, enable_clr = 1'b0;
    logic master_set = 1'b0, master_clr = 1'b0;
    logic done_clr = 1'b0, fault_clr = 1'b0, tx_write = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte;
    logic mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe;
    logic sel_out, sel_oe, sel_routed, port_enable_bit, master_enable_bit;
    logic mode_fault_flag, transfer_done_flag, busy;
    logic sck_p, mosi_p, miso_p, sel_p;
    int num_errors = 0, n_compared = 0, cycles = 0;
    // pin levels resolved from the DUT driver enables; the far end drives whenever the DUT does not
    wire logic sck_w = sck_oe ? sck_out : sck_p;
    wire logic mosi_w = mosi_oe ? mosi_out : mosi_p;
    wire logic miso_w = miso_oe ? miso_out : miso_p;

    spi_port i_dut (.clk_sys, .reset_n, .clk_en, .select_mode_field,
        .enable_set, .enable_clr, .master_set, .master_clr, .tx_byte,
        .tx_write, .done_clr, .fault_clr, .mosi_in(mosi_w),
        .miso_in(miso_w), .sck_in(sck_w), .sel_in(sel_p), .mosi_out,
        .mosi_oe, .miso_out, .miso_oe, .sck_out, .sck_oe, .sel_out,
        .sel_oe, .sel_routed, .port_enable_bit, .master_enable_bit,
        .mode_fault_flag, .transfer_done_flag, .rx_byte, .busy);
    spi_far_end i_far (.sck_w, .mosi_w, .miso_w, .sck_p, .mosi_p,
        .miso_p, .sel_p);

    always #25 clk_sys = ~clk_sys;
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("errors %0d, compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // pulse {en_set, en_clr, m_set, m_clr, done_clr, fault_clr}
    task automatic ctl(input logic [5:0] v);
        @(posedge clk_sys);
        {enable_set, enable_clr, master_set, master_clr, done_clr,
            fault_clr} <= v;
        @(posedge clk_sys);
        {enable_set, enable_clr, master_set, master_clr, done_clr,
            fault_clr} <= 6'h00;
        waitc(3);
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        tx_byte <= b;
        tx_write <= 1'b1;
        @(posedge clk_sys);
        tx_write <= 1'b0;
    endtask
    // bounded wait on the done flag, then clear it
    task automatic wait_done(input logic [7:0] rx_exp);
        int i;
        i = 0;
        while (transfer_done_flag !== 1'b1 && i < 200) begin
            @(posedge clk_sys);
            i++;
        end
        check(transfer_done_flag, 8'h01);
        check(rx_byte, rx_exp);
        ctl(6'h02);
    endtask

    task automatic t_master;
        select_mode_field <= 2'h0;
        ctl(6'h28);
        i_far.sh_q <= 8'h3C;
        send(8'hA5);
        waitc(3);
        check({busy, mosi_oe, sck_oe, miso_oe}, 8'h0E);
        check(sel_routed, 8'h00);
        wait_done(8'h3C);
        check(i_far.got_q, 8'hA5);
        select_mode_field <= 2'h2;
        waitc(4);
        check({sel_oe, sel_out, sel_routed}, 8'h05);
        select_mode_field <= 2'h3;
        waitc(4);
        check(sel_out, 8'h01);
    endtask
    task automatic t_slave3;
        select_mode_field <= 2'h0;
        ctl(6'h04);
        send(8'h96);
        waitc(4);
        check({miso_oe, sck_oe, mosi_oe}, 8'h04);
        i_far.xfer(8'h5A, 8, 200);
        wait_done(8'h5A);
        check(i_far.got_q, 8'h96);
    endtask
    // select held high: clock ignored; aborted byte then a fresh one
    task automatic t_slave4;
        select_mode_field <= 2'h1;
        waitc(4);
        check(miso_oe, 8'h00);
        i_far.xfer(8'hFF, 8, 200);
        waitc(8);
        check(transfer_done_flag, 8'h00);
        i_far.sel_p <= 1'b0;
        i_far.xfer(8'h00, 3, 200);
        i_far.sel_p <= 1'b1;
        waitc(8);
        i_far.sel_p <= 1'b0;
        waitc(4);
        send(8'hC3);
        waitc(4);
        check(miso_oe, 8'h01);
        i_far.xfer(8'h81, 8, 300);
        wait_done(8'h81);
        check(i_far.got_q, 8'hC3);
    endtask
    task automatic t_fault;
        i_far.sel_p <= 1'b1;
        ctl(6'h08);
        check(master_enable_bit, 8'h01);
        i_far.sel_p <= 1'b0;
        waitc(8);
        check({mode_fault_flag, master_enable_bit, port_enable_bit},
            8'h04);
        // a clear while the clock enable is low must not land
        clk_en <= 1'b0;
        ctl(6'h01);
        check(mode_fault_flag, 8'h01);
        clk_en <= 1'b1;
        ctl(6'h01);
        check(mode_fault_flag, 8'h00);
        select_mode_field <= 2'h0;
        ctl(6'h20);
        check(miso_oe, 8'h01);
        ctl(6'h10);
        check(miso_oe, 8'h00);
    endtask

    initial begin
        waitc(4);
        reset_n <= 1'b1;
        waitc(1);
        check({sel_out, port_enable_bit, miso_oe, mosi_oe}, 8'h08);
        t_master();
        t_slave3();
        t_slave4();
        t_fault();
        give_verdict();
    end
endmodule
`default_nettype wire
